// File: rtl/calibration_table_selector.v
// Calibration table selector with overdrive, speedometer and shift outputs
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "table_select_regs.vh"
module calibration_table_selector #(
	parameter [31:0] DEBOUNCE_CYC = `DEBOUNCE_CYC,
	parameter [31:0] OD_HOLD_CYC = `OD_HOLD_CYC
) (
	// Clock and reset
	input wire mclk,
	input wire nrst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Vehicle switches, low level means grounded
	input wire table_sel_n,
	input wire od_switch,
	input wire low_range_n,
	input wire knob_click,
	input wire status_screen,
	input wire four_wd,
	input wire [1:0] low_range_num,
	// Transmission state
	input wire shift_active,
	// Speed sensor and speedometer
	input wire speed_sensor,
	output reg speedo_pulse_out,
	output reg speedo_ac_mode,
	// Outputs to engine side and lamp
	output reg shift_in_progress_n,
	output reg od_lamp_sink,
	// Display
	output reg [1:0] active_table,
	output reg table_indicator_update,
	output reg [1:0] gear_position_indicator,
	output reg gear_indicator_update,
	output reg first_low_range_tag,
	output reg second_low_range_tag,
	output reg third_low_range_tag
);
	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	reg rst_s1_r;
	reg rst_n_r;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// ------------------------------------------------------------
	// Switch conditioning
	// ------------------------------------------------------------
	wire [3:0] raw_in;
	wire [3:0] lvl;
	wire [3:0] rise;
	// Grounded pins invert so that high means switch on
	assign raw_in = {knob_click, ~low_range_n, od_switch, ~table_sel_n}; // [RL1]
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sw
			switch_conditioner #(
				.DEBOUNCE_CYC(DEBOUNCE_CYC)
			) u_sw (
				.mclk(mclk),
				.rst_n(rst_n_r),
				.raw(raw_in[gi]),
				.level_r(lvl[gi]),
				.rise(rise[gi])
			);
		end
	endgenerate
	wire ts_on = lvl[0];
	wire od_on = lvl[1];
	wire low_on = lvl[2];

	// Same-clock inputs from other pins pass two flops
	reg [4:0] misc_s1_r;
	reg [4:0] misc_r;
	reg spd_s1_r;
	reg spd_s2_r;
	reg spd_d_r;
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			misc_s1_r <= 5'h00;
			misc_r <= 5'h00;
			spd_s1_r <= 1'b0;
			spd_s2_r <= 1'b0;
			spd_d_r <= 1'b0;
		end else begin
			misc_s1_r <= {shift_active, status_screen, four_wd, low_range_num};
			misc_r <= misc_s1_r;
			spd_s1_r <= speed_sensor;
			spd_s2_r <= spd_s1_r;
			spd_d_r <= spd_s2_r;
		end
	end
	wire [1:0] lo_num = misc_r[1:0];
	wire fwd = misc_r[2];
	wire on_status = misc_r[3];
	wire shifting = misc_r[4];
	wire spd_edge = spd_s2_r ^ spd_d_r;

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	reg [31:0] ctrl_r;
	reg [31:0] speedo_r;
	reg [31:0] tune_r;
	wire [2:0] sel_mode = ctrl_r[`CTRL_SEL_MODE_LSB+2:`CTRL_SEL_MODE_LSB];
	wire ts_momentary = ctrl_r[`CTRL_TS_MOMENTARY];
	wire od_momentary = ctrl_r[`CTRL_OD_MOMENTARY];
	wire manual_en = ctrl_r[`CTRL_MANUAL_EN];
	wire low_det_en = ctrl_r[`CTRL_LOW_DET_EN];
	wire knob_od = ctrl_r[`CTRL_KNOB_OD];
	wire knob_table = ctrl_r[`CTRL_KNOB_TABLE];
	wire [1:0] tables_used =
		ctrl_r[`CTRL_TABLES_USED_LSB+1:`CTRL_TABLES_USED_LSB];
	wire [2:0] spo_mode = speedo_r[`SPEEDO_MODE_LSB+2:`SPEEDO_MODE_LSB];
	wire [15:0] spo_ratio = speedo_r[15:0];
	wire wr = psel & penable & pwrite;
	wire [1:0] od_state;

	// APB writes; speedo reset reloads tune values
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ctrl_r <= `CTRL_RESET;
			speedo_r <= `SPEEDO_RESET;
			tune_r <= `SPEEDO_RESET;
		end else if (wr) begin
			case (paddr)
				`REG_CTRL: begin
					ctrl_r <= pwdata & ~(32'h1 << `CTRL_SPEEDO_RESET);
					if (pwdata[`CTRL_SPEEDO_RESET])
						speedo_r <= tune_r; // [RL15]
				end
				`REG_SPEEDO: speedo_r <= pwdata & 32'h0007_FFFF; // [RL13]
				`REG_TUNE: tune_r <= pwdata & 32'h0007_FFFF;
				default: ctrl_r <= ctrl_r;
			endcase
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel & penable & (paddr > `REG_STATUS | paddr[1:0] != 2'h0);

	// Read mux
	always @* begin
		case (paddr)
			`REG_CTRL: prdata = ctrl_r;
			`REG_SPEEDO: prdata = speedo_r;
			`REG_TUNE: prdata = tune_r;
			`REG_STATUS: prdata = {24'h000000, od_state, gear_position_indicator,
				~shift_in_progress_n, low_on, active_table};
			default: prdata = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// Overdrive button hold timer and knob click
	// ------------------------------------------------------------
	reg [31:0] hold_cnt_r;
	reg hold_done_r;
	reg hold_pulse_r;
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			hold_cnt_r <= 32'h0000_0000;
			hold_done_r <= 1'b0;
			hold_pulse_r <= 1'b0;
		end else begin
			hold_pulse_r <= 1'b0;
			if (!od_on) begin
				hold_cnt_r <= 32'h0000_0000;
				hold_done_r <= 1'b0;
			end else if (!hold_done_r) begin
				if (hold_cnt_r >= OD_HOLD_CYC - 32'd1) begin
					hold_done_r <= 1'b1;
					hold_pulse_r <= 1'b1; // [RL5]
				end else begin
					hold_cnt_r <= hold_cnt_r + 32'd1;
				end
			end
		end
	end
	wire knob_ev = rise[3];
	wire alt_select = hold_pulse_r | (knob_ev & knob_table & on_status); // [RL5]

	// ------------------------------------------------------------
	// Overdrive state machine
	// ------------------------------------------------------------
	reg [1:0] od_r;
	reg od_rel_r;
	// Release of a held button after a 2 s hold is not a press
	wire od_press = ~od_on & od_rel_r & ~hold_done_r;
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			od_r <= `OD_ON;
			od_rel_r <= 1'b0;
		end else begin
			od_rel_r <= od_on;
			if (knob_od & knob_ev & ~(knob_table & on_status)) begin
				od_r <= (od_r == `OD_ON) ? `OD_OFF : `OD_ON; // [RL19]
			end else if (!od_momentary) begin
				od_r <= od_on ? `OD_OFF : `OD_ON; // [RL17]
			end else if (od_press) begin
				case (od_r) // [RL17]
					`OD_ON: od_r <= `OD_OFF;
					`OD_OFF: od_r <= manual_en ? `OD_MANUAL : `OD_ON;
					`OD_MANUAL: od_r <= `OD_ON;
					default: od_r <= `OD_ON;
				endcase
			end
		end
	end
	assign od_state = od_r;

	// ------------------------------------------------------------
	// Table selection
	// ------------------------------------------------------------
	reg [1:0] cycle_r;
	reg [1:0] table_nxt;
	wire step = (ts_momentary & rise[0]) | alt_select;
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cycle_r <= 2'h0;
		end else if (step) begin
			if (cycle_r >= tables_used)
				cycle_r <= 2'h0; // [RL4]
			else
				cycle_r <= cycle_r + 2'h1; // [RL4]
		end
	end

	// Mode-dependent choice of table, coded 0..3 for tables 1..4
	always @* begin
		case (sel_mode)
			`MODE_4WD_ONLY: begin
				if (!low_on)
					table_nxt = 2'h0; // [RL6]
				else if (lo_num == 2'h2)
					table_nxt = 2'h2; // [RL6]
				else if (lo_num == 2'h3)
					table_nxt = 2'h3; // [RL6]
				else
					table_nxt = 2'h1; // [RL6]
			end
			`MODE_SWITCH_4WD: table_nxt = {fwd, ts_on}; // [RL7]
			`MODE_OD: begin
				case (od_r) // [RL8]
					`OD_ON: table_nxt = 2'h0;
					`OD_OFF: table_nxt = 2'h1;
					default: table_nxt = manual_en ? 2'h2 : 2'h1;
				endcase
			end
			default: begin
				if (ts_momentary | knob_table)
					table_nxt = cycle_r; // [RL4]
				else
					table_nxt = {1'b0, ts_on}; // [RL2] [RL3]
			end
		endcase
		if (low_det_en & low_on & sel_mode != `MODE_4WD_ONLY)
			table_nxt = 2'h1; // [RL9]
	end

	// ------------------------------------------------------------
	// Display, lamp and shift outputs
	// ------------------------------------------------------------
	reg [1:0] gpi_nxt;
	always @* begin
		case (od_r) // [RL20]
			`OD_ON: gpi_nxt = `GPI_O;
			`OD_OFF: gpi_nxt = `GPI_D;
			default: gpi_nxt = `GPI_3;
		endcase
	end
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			active_table <= 2'h0;
			table_indicator_update <= 1'b0;
			gear_position_indicator <= `GPI_O;
			gear_indicator_update <= 1'b0;
			first_low_range_tag <= 1'b0;
			second_low_range_tag <= 1'b0;
			third_low_range_tag <= 1'b0;
			od_lamp_sink <= 1'b0;
			shift_in_progress_n <= 1'b1;
		end else begin
			active_table <= table_nxt;
			table_indicator_update <= (table_nxt != active_table); // [RL11]
			gear_position_indicator <= gpi_nxt;
			gear_indicator_update <= (gpi_nxt != gear_position_indicator); // [RL20]
			first_low_range_tag <= low_on & (lo_num < 2'h2); // [RL10]
			second_low_range_tag <= low_on & (lo_num == 2'h2); // [RL10]
			third_low_range_tag <= low_on & (lo_num == 2'h3); // [RL10]
			od_lamp_sink <= (od_r != `OD_ON); // [RL18]
			shift_in_progress_n <= ~shifting; // [RL16]
		end
	end

	// ------------------------------------------------------------
	// Speedometer output
	// ------------------------------------------------------------
	// Period of sensor half-cycle measured, output half-cycle scaled
	reg [23:0] in_cnt_r;
	reg [23:0] in_per_r;
	reg [31:0] out_cnt_r;
	wire [39:0] scaled = {16'h0000, in_per_r} << 8;
	wire [39:0] quot = scaled / {24'h000000, spo_ratio};
	// Zero ratio parks the output instead of dividing by zero
	wire [31:0] out_half = (spo_ratio == 16'h0000) ? 32'hFFFF_FFFF :
		quot[31:0];
	always @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			in_cnt_r <= 24'h000000;
			in_per_r <= 24'h000000;
			out_cnt_r <= 32'h0000_0000;
			speedo_pulse_out <= 1'b0;
			speedo_ac_mode <= 1'b0;
		end else begin
			speedo_ac_mode <= (spo_mode == `SPO_AC5); // [RL13]
			if (spd_edge) begin
				in_per_r <= in_cnt_r + 24'h000001; // Full half-cycle length
				in_cnt_r <= 24'h000000;
			end else if (in_cnt_r != 24'hFFFFFF) begin
				in_cnt_r <= in_cnt_r + 24'h000001;
			end
			case (spo_mode)
				`SPO_DISABLED: speedo_pulse_out <= 1'b0; // [RL13]
				`SPO_REPLICATED: speedo_pulse_out <= spd_s2_r; // [RL14]
				default: begin
					if (in_per_r == 24'h000000 || in_cnt_r == 24'hFFFFFF) begin
						out_cnt_r <= 32'h0000_0000;
						speedo_pulse_out <= 1'b0;
					end else if (out_cnt_r + 32'd1 >= out_half) begin
						out_cnt_r <= 32'h0000_0000;
						speedo_pulse_out <= ~speedo_pulse_out; // [RL12]
					end else begin
						out_cnt_r <= out_cnt_r + 32'd1;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: rtl/switch_conditioner.v
// Two-flop synchroniser and debounce filter for one switch input
`timescale 1ns/1ps
`default_nettype none
module switch_conditioner #(
	parameter [31:0] DEBOUNCE_CYC = 32'd1250000
) (
	// Clock and reset
	input wire mclk,
	input wire rst_n,
	// Raw pin and cleaned result
	input wire raw,
	output reg level_r,
	output wire rise
);
	reg sync1_r;
	reg sync2_r;
	reg [31:0] cnt_r;
	reg level_d_r;

	// ------------------------------------------------------------
	// Synchronise, then accept a level only after it stays stable
	// ------------------------------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			cnt_r <= 32'h0000_0000;
			level_r <= 1'b0;
			level_d_r <= 1'b0;
		end else begin
			sync1_r <= raw;
			sync2_r <= sync1_r;
			level_d_r <= level_r;
			if (sync2_r == level_r) begin
				cnt_r <= 32'h0000_0000;
			end else if (cnt_r >= DEBOUNCE_CYC - 32'd1) begin
				level_r <= sync2_r; // [RL21]
				cnt_r <= 32'h0000_0000;
			end else begin
				cnt_r <= cnt_r + 32'd1;
			end
		end
	end

	// One event per accepted press
	assign rise = level_r & ~level_d_r; // [RL21]
endmodule
`default_nettype wire

// File: rtl/table_select_regs.vh
// Constants for the calibration table selector and its APB registers
//
// What this block does
// RL1 - A grounded table-select input means the switch is on.
// RL2 - Latching selector: table 2 while asserted, table 1 while released.
// RL3 - Latching selector reaches only those two tables.
// RL4 - Momentary selector: each press advances 1-2-3-4-1 over tables in use.
// RL5 - Overdrive held 2 seconds, or knob click on status, selects table.
// RL6 - 4WD-only mode: table 1 for 2WD/high, 2 for low, 3-4 for later lows.
// RL7 - Switch-plus-4WD mode: tables 1/2 in 2WD, 3/4 in 4WD by switch.
// RL8 - Overdrive mode: table 1 on, table 2 off, table 3 manual if enabled.
// RL9 - Low-range detection on and input grounded selects table 2.
// RL10 - Up to three low ranges, each with its own tag beside speed.
// RL11 - Every table change updates the table indicator.
// RL12 - Adjustable speedometer: output is sensor frequency times a factor.
// RL13 - Speedo modes: 5V AC, 12V pulse, off, replicated, adjustable, reset.
// RL14 - Replicated speedometer reproduces sensor edges with no ratio.
// RL15 - Speedometer reset restores mode and ratio from the loaded tune.
// RL16 - Shift-in-progress output low during a shift, released otherwise.
// RL17 - Latching overdrive gives two states; momentary steps on, off, manual.
// RL18 - Overdrive lamp sinks current while overdrive is off.
// RL19 - When configured, a knob click toggles overdrive.
// RL20 - Overdrive or manual change updates the gear position indicator.
// RL21 - Switch inputs are synchronised and debounced, one event per press.
`ifndef TABLE_SELECT_REGS_VH
`define TABLE_SELECT_REGS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define REG_CTRL 12'h000
`define REG_SPEEDO 12'h004
`define REG_TUNE 12'h008
`define REG_STATUS 12'h00C

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define CTRL_SEL_MODE_LSB 0
`define CTRL_TS_MOMENTARY 3
`define CTRL_OD_MOMENTARY 4
`define CTRL_MANUAL_EN 5
`define CTRL_LOW_DET_EN 6
`define CTRL_KNOB_OD 7
`define CTRL_KNOB_TABLE 8
`define CTRL_TABLES_USED_LSB 9
`define CTRL_SPEEDO_RESET 11
`define CTRL_RESET 32'h0000_0000

// Selection modes
`define MODE_SWITCH 3'h0
`define MODE_4WD_ONLY 3'h1
`define MODE_SWITCH_4WD 3'h2
`define MODE_OD 3'h3

// Speedometer modes
`define SPO_AC5 3'h0
`define SPO_PULSE12 3'h1
`define SPO_DISABLED 3'h2
`define SPO_REPLICATED 3'h3
`define SPO_ADJUSTABLE 3'h4

// Speedometer register: mode [18:16], ratio 8.8 fixed point [15:0]
`define SPEEDO_MODE_LSB 16
`define SPEEDO_RESET 32'h0004_0100

// Overdrive states
`define OD_ON 2'h0
`define OD_OFF 2'h1
`define OD_MANUAL 2'h2

// Gear position indicator codes: O, D, 3
`define GPI_O 2'h0
`define GPI_D 2'h1
`define GPI_3 2'h2

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_MHZ 250
`define DEBOUNCE_US 5000
`define DEBOUNCE_CYC (`DEBOUNCE_US * `CLK_MHZ)
`define OD_HOLD_MS 2000
`define OD_HOLD_CYC (`OD_HOLD_MS * 1000 * `CLK_MHZ)

`endif

// File: verification/table_sel_check_assertions.sv
// Port assertions for the calibration table selector
`timescale 1ns/1ps
`default_nettype none
module table_sel_check #(
	parameter [31:0] DEBOUNCE_CYC = 32'd4,
	parameter [31:0] OD_HOLD_CYC = 32'd20
) (
	// Clock, reset and bus
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// Vehicle side and display
	input wire logic shift_active,
	input wire logic shift_in_progress_n,
	input wire logic od_lamp_sink,
	input wire logic [1:0] active_table,
	input wire logic table_indicator_update,
	input wire logic [1:0] gear_position_indicator,
	input wire logic gear_indicator_update,
	input wire logic first_low_range_tag,
	input wire logic second_low_range_tag,
	input wire logic third_low_range_tag
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	// ----
	// Building blocks
	// ----
	sequence acc_s;
		psel && penable;
	endsequence
	sequence held_s(b);
		b [*4];
	endsequence
	// ----
	// Checks
	// ----
	bus_ready_a: assert property (acc_s |-> pready)
		else $error("no ready in access");
	bad_addr_a: assert property (acc_s ##0 paddr > 12'h00C |-> pslverr)
		else $error("unmapped access not refused");
	good_addr_a: assert property (acc_s ##0 (paddr <= 12'h00C &&
		paddr[1:0] == 2'h0) |-> !pslverr)
		else $error("mapped access refused");
	shift_low_a: assert property (
		held_s(shift_active) |-> !shift_in_progress_n)
		else $error("shift output not low");
	shift_idle_a: assert property (
		held_s(!shift_active) |-> shift_in_progress_n)
		else $error("shift output not released");
	table_upd_a: assert property (
		$changed(active_table) |-> table_indicator_update)
		else $error("table change without update");
	upd_cause_a: assert property (
		table_indicator_update |-> $changed(active_table))
		else $error("update without table change");
	gear_upd_a: assert property (
		$changed(gear_position_indicator) |-> gear_indicator_update)
		else $error("gear indicator change without update");
	lamp_state_a: assert property (
		$stable(gear_position_indicator) [*2] |->
		od_lamp_sink == (gear_position_indicator != 2'h0))
		else $error("lamp disagrees with overdrive");
	low_tag_a: assert property ($onehot0({first_low_range_tag,
		second_low_range_tag, third_low_range_tag}))
		else $error("more than one low range tag");
endmodule
bind calibration_table_selector table_sel_check #(
	.DEBOUNCE_CYC(DEBOUNCE_CYC),
	.OD_HOLD_CYC(OD_HOLD_CYC)
) chk (.mclk, .nrst, .psel, .penable, .paddr, .pready, .pslverr,
	.shift_active, .shift_in_progress_n, .od_lamp_sink, .active_table,
	.table_indicator_update, .gear_position_indicator, .gear_indicator_update,
	.first_low_range_tag, .second_low_range_tag, .third_low_range_tag);
`default_nettype wire

// File: verification/test_calibration_table_selector.sv
// Self-checking bench for the calibration table selector
`timescale 1ns/1ps
`default_nettype none
`include "table_select_regs.vh"
module test_calibration_table_selector;
	logic mclk, nrst, psel, penable, pwrite, pready, pslverr, err, run, spo_q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, t;
	logic table_sel_n, od_switch, low_range_n, knob_click, status_screen;
	logic four_wd, shift_active, speed_sensor, speedo_pulse_out;
	logic speedo_ac_mode, shift_in_progress_n, od_lamp_sink;
	logic table_indicator_update, gear_indicator_update;
	logic first_low_range_tag, second_low_range_tag, third_low_range_tag;
	logic [1:0] low_range_num, active_table, gear_position_indicator;
	logic [7:0] half;
	int error_cnt, checked, cyc, edges, spo_edges, i, od, n0, n1;

	calibration_table_selector #(.DEBOUNCE_CYC(4), .OD_HOLD_CYC(20)) dut (
		.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .table_sel_n, .od_switch, .low_range_n,
		.knob_click, .status_screen, .four_wd, .low_range_num, .shift_active,
		.speed_sensor, .speedo_pulse_out, .speedo_ac_mode,
		.shift_in_progress_n, .od_lamp_sink, .active_table,
		.table_indicator_update, .gear_position_indicator,
		.gear_indicator_update, .first_low_range_tag, .second_low_range_tag,
		.third_low_range_tag);
	vehicle_side peer (.mclk, .nrst, .run, .half, .speed_sensor, .edges);

	// Clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	// Hang limit and output edge counter
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		spo_q <= speedo_pulse_out;
		if (speedo_pulse_out && !spo_q)
			spo_edges++;
		if (cyc == 12000) begin
			error_cnt++;
			results();
		end
	end
	// ----
	// Model and helpers
	// ----
	function automatic int exp_tbl(int m, int sw, int w4, int lo, int num,
		int ld);
		if (m == 1)
			return (w4 && lo) ? ((num == 0) ? 1 : num) : 0;
		if (m == 2)
			return w4 * 2 + sw;
		if (ld && lo)
			return 1;
		return sw;
	endfunction
	task check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task settle;
		repeat (16) @(posedge mclk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1)
			@(posedge mclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task put(input int sw, w4, lo, num, m, ld);
		table_sel_n <= !sw[0];
		four_wd <= w4[0];
		low_range_n <= !lo[0];
		low_range_num <= num[1:0];
		settle;
		check(active_table, exp_tbl(m, sw, w4, lo, num, ld));
	endtask
	task press(input int s);
		if (s == 0)
			table_sel_n <= 1'b0;
		else if (s == 1)
			od_switch <= 1'b1;
		else
			knob_click <= 1'b1;
		settle;
		table_sel_n <= 1'b1;
		od_switch <= 1'b0;
		knob_click <= 1'b0;
		settle;
	endtask
	task chk_od;
		check(active_table, od);
		check(gear_position_indicator, od);
		check(od_lamp_sink, od != 0);
	endtask
	task spo_run(input logic [31:0] v);
		apb(1'b1, `REG_SPEEDO, v);
		n0 = edges;
		n1 = spo_edges;
		run <= 1'b1;
		repeat (400) @(posedge mclk);
		run <= 1'b0;
		settle;
		n0 = edges - n0;
		n1 = spo_edges - n1;
	endtask
	task results;
		$display("mismatches %0d, checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----
	// Main sequence
	// ----
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, run} = '0;
		{od_switch, knob_click, status_screen, four_wd, shift_active} = '0;
		{low_range_num, error_cnt, checked, cyc, spo_edges} = '0;
		table_sel_n = 1'b1;
		low_range_n = 1'b1;
		half = 8'd8;
		void'($urandom(60313));
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		rdc(`REG_CTRL, `CTRL_RESET);
		rdc(`REG_TUNE, `SPEEDO_RESET);
		apb(1'b0, 12'h010, 32'h0);
		check(err, 1'b1);
		for (i = 0; i < 4; i++)
			put((i + 1) % 2, 0, 0, 0, 0, 0);
		apb(1'b1, `REG_CTRL, 32'h0000_0608);
		for (i = 1; i < 6; i++) begin
			press(0);
			check(active_table, i % 4);
		end
		apb(1'b1, `REG_CTRL, 32'h0000_0708);
		status_screen <= 1'b1;
		press(2);
		check(active_table, 2);
		status_screen <= 1'b0;
		// Overdrive held past the hold time steps the table once
		od_switch <= 1'b1;
		repeat (40) @(posedge mclk);
		od_switch <= 1'b0;
		settle;
		check(active_table, 3);
		apb(1'b1, `REG_CTRL, 32'h0000_0001);
		put(0, 0, 0, 0, 1, 0);
		for (i = 1; i < 4; i++) begin
			put(0, 1, 1, i, 1, 0);
			check({third_low_range_tag, second_low_range_tag,
				first_low_range_tag}, 1 << (i - 1));
		end
		put(0, 1, 0, 0, 1, 0);
		apb(1'b1, `REG_CTRL, 32'h0000_0002);
		for (i = 0; i < 4; i++)
			put(i % 2, i / 2, 0, 0, 2, 0);
		apb(1'b1, `REG_CTRL, 32'h0000_0040);
		put(0, 0, 1, 1, 0, 1);
		put(0, 0, 0, 0, 0, 1);
		shift_active <= 1'b1;
		settle;
		check(shift_in_progress_n, 1'b0);
		shift_active <= 1'b0;
		settle;
		check(shift_in_progress_n, 1'b1);
		apb(1'b1, `REG_CTRL, 32'h0000_0003);
		// Switch on means overdrive off; end released so the hold clears
		for (i = 1; i >= 0; i--) begin
			od_switch <= i[0];
			od = i;
			settle;
			chk_od;
		end
		apb(1'b1, `REG_CTRL, 32'h0000_00B3);
		for (i = 0; i < 3; i++) begin
			press(1);
			od = (od + 1) % 3;
			chk_od;
		end
		press(2);
		od = (od == 0) ? 1 : 0;
		chk_od;
		// Even half periods keep a ratio of two free of rounding
		half <= 8'(8 + 2 * ($urandom % 4));
		for (i = 0; i < 5; i++) begin
			apb(1'b1, `REG_SPEEDO, {13'h0, i[2:0], 16'h0100});
			repeat (2) @(posedge mclk);
			check(speedo_ac_mode, i == 0);
		end
		spo_run(32'h0002_0100);
		check(n1, 0);
		spo_run(32'h0003_0100);
		check(n1, n0);
		spo_run(32'h0004_0200);
		check(n1 >= 2 * n0 - 4 && n1 <= 2 * n0 + 4, 1);
		t = {13'h0, 3'h4, 16'($urandom)};
		apb(1'b1, `REG_TUNE, t);
		rdc(`REG_TUNE, t);
		apb(1'b1, `REG_CTRL, 32'h0000_08B3);
		rdc(`REG_SPEEDO, t);
		rdc(`REG_STATUS, {24'h0, od[1:0], od[1:0], 2'h0, od[1:0]});
		results();
	end
endmodule
`default_nettype wire

// File: verification/vehicle_side.sv
// Speed sensor source standing on the vehicle side
`timescale 1ns/1ps
`default_nettype none
module vehicle_side (
	// Clock, reset and control
	input wire logic mclk,
	input wire logic nrst,
	input wire logic run,
	input wire logic [7:0] half,
	// Sensor wave and its rising edge count
	output logic speed_sensor,
	output int edges
);
	int cnt;
	// Square wave while running, parked low between runs
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			speed_sensor <= 1'b0;
			edges <= 0;
			cnt <= 0;
		end else if (!run) begin
			speed_sensor <= 1'b0;
			cnt <= 0;
		end else if (cnt >= half - 1) begin
			cnt <= 0;
			speed_sensor <= !speed_sensor;
			if (!speed_sensor)
				edges <= edges + 1;
		end else
			cnt <= cnt + 1;
	end
endmodule
`default_nettype wire
